// file: hdl/hbp_pkg.sv
// Shared constants and types of the host bus port
`default_nettype none
package hbp_pkg;
  localparam int AD_W = 32;
  localparam int BE_W = 4;
  localparam int SCR_WORDS = 4;
  localparam int SCR_IDX_W = 2;
  localparam int IDX_LSB = 2;
  localparam int WIN_LSB = 4;
  // Bus cycles without a device-select answer before a master abort
  localparam int ABORT_CYCLES = 5;
  localparam int ABORT_CNT_W = 4;
  localparam logic [AD_W-1:0] AD_RST = 32'h0000_0000;
  localparam logic [BE_W-1:0] BE_RST = 4'hF;
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [2:0] ST_LP_RD = 3'h0;
  localparam logic [2:0] ST_HP_RD = 3'h1;
  localparam logic [2:0] ST_LP_WR = 3'h2;
  localparam logic [2:0] ST_HP_WR = 3'h3;
  localparam logic [2:0] ST_START = 3'h7;
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_MDATA = 9'h004,
    S_PIPE = 9'h008,
    S_AGPW = 9'h010,
    S_AGPR = 9'h020,
    S_TDATA = 9'h040,
    S_TSTOP = 9'h080,
    S_TURN = 9'h100
  } hbp_state_t;
endpackage
`default_nettype wire

// file: hdl/hbp_sync.sv
// Two-flop synchroniser for levels and toggles
`default_nettype none
module hbp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // hbp_sync
`default_nettype wire

// file: hdl/hbp_parity.sv
// Even parity over a word
`default_nettype none
module hbp_parity #(
  parameter int W = 36
) (
  input wire logic [W-1:0] data,
  output logic par
);
  // Bit that makes the count of ones, itself included, even
  assign par = ^data;
endmodule // hbp_parity
`default_nettype wire

// file: hdl/hbp_pci_agp_port.sv
// Host bus port: master, target and AGP sequencing on the bus clock
`default_nettype none
module hbp_pci_agp_port #(
  parameter int ABORT_CYC = hbp_pkg::ABORT_CYCLES,
  parameter logic [31:0] MEM_BASE = 32'h0000_0000
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mstStart,
  input wire logic mstAgp,
  input wire logic mstWrite,
  input wire logic [3:0] mstCmd,
  input wire logic [31:0] mstAddr,
  input wire logic [31:0] mstData,
  input wire logic [3:0] mstBe_b,
  input wire logic readBufFull,
  input wire logic agpMode,
  output logic mstBusy,
  output logic mstDone,
  output logic mstAbort,
  output logic mstParErr,
  output logic [31:0] mstRdData,
  output logic rdRetValid,
  output logic rdRetHigh,
  output logic [31:0] rdRetData,
  input wire logic busClk,
  input wire logic busRst_b,
  input wire logic [31:0] adIn,
  output logic [31:0] adOut,
  output logic adOe,
  input wire logic [3:0] cbeIn_b,
  output logic [3:0] cbeOut_b,
  output logic cbeOe,
  input wire logic parIn,
  output logic parOut,
  output logic parOe,
  input wire logic frameIn_b,
  output logic frameOut_b,
  output logic frameOe,
  input wire logic irdyIn_b,
  output logic irdyOut_b,
  output logic irdyOe,
  input wire logic trdyIn_b,
  output logic trdyOut_b,
  output logic trdyOe,
  input wire logic stopIn_b,
  output logic stopOut_b,
  output logic stopOe,
  input wire logic devselIn_b,
  output logic devselOut_b,
  output logic devselOe,
  input wire logic idsel,
  input wire logic gnt_b,
  input wire logic [2:0] agpSt,
  output logic reqOut_b,
  output logic reqOe,
  output logic pipeOut_b,
  output logic pipeOe,
  output logic rbfOut_b,
  output logic rbfOe
);
  // Core-side request, held stable while busy
  logic cReqTgl_q, cAgp_q, cWrite_q, mstBusy_q, mstDone_q, mstAbort_q, mstParErr_q;
  logic [3:0] cCmd_q, cBe_q;
  logic [31:0] cAddr_q, cData_q, mstRdData_q, rdRetData_q;
  logic rdRetValid_q, rdRetHigh_q, cDoneSeen_q, cRetSeen_q;
  logic [1:0] cSync;
  // Bus-side state
  hbp_pkg::hbp_state_t stQ;
  logic [2:0] bSync;
  logic bReqSeen_q, bReqPend_q, bAgpWrPend_q, bFramePrev_q, tWr_q, bHigh_q;
  logic bDoneTgl_q, bRetTgl_q, bMstEnd_q, bChk_q, bAbort_q, bParErr_q;
  logic [hbp_pkg::SCR_IDX_W-1:0] tIdx_q;
  logic [hbp_pkg::ABORT_CNT_W-1:0] abortCnt_q;
  logic [31:0] bRdData_q, bRetData_q, adOut_q;
  logic [31:0] scr_q [hbp_pkg::SCR_WORDS];
  logic [3:0] cbeOut_b_q, cbeBus;
  logic adOe_q, cbeOe_q, parOut_q, parOe_q, frameOut_b_q, frameOe_q, irdyOut_b_q, irdyOe_q;
  logic trdyOut_b_q, trdyOe_q, stopOut_b_q, stopOe_q, devselOut_b_q, devselOe_q;
  logic reqOut_b_q, reqOe_q, pipeOut_b_q, pipeOe_q, rbfOut_b_q, rbfOe_q;
  logic parNext, parChk;
  logic busIdle, xferDone, frameFall, cfgHit, memHit, tHit, goMst, agpRdGo, agpWrGo;
  logic [3:0] cmdIn;
  localparam logic [hbp_pkg::ABORT_CNT_W-1:0] ABORT_CNT_LAST = hbp_pkg::ABORT_CNT_W'(ABORT_CYC - 1);

  // Core to bus: request toggle plus buffer-full and mode levels
  hbp_sync #(.W(3)) uBusSync (
    .clk(busClk),
    .rst_b(busRst_b),
    .d({cReqTgl_q, readBufFull, agpMode}),
    .q(bSync)
  );
  // Bus to core: completion and read-return toggles
  hbp_sync #(.W(2)) uCoreSync (
    .clk(clock),
    .rst_b(rst_b),
    .d({bDoneTgl_q, bRetTgl_q}),
    .q(cSync)
  );

  assign cbeBus = cbeOe_q ? cbeOut_b_q : cbeIn_b;
  hbp_parity #(.W(36)) uParGen (
    .data({adOut_q, cbeBus}),
    .par(parNext)
  );
  hbp_parity #(.W(36)) uParChk (
    .data({bRdData_q, cbeOut_b_q}),
    .par(parChk)
  );

  assign busIdle = frameIn_b && irdyIn_b;
  assign xferDone = !irdyIn_b && !trdyIn_b;
  assign frameFall = !frameIn_b && bFramePrev_q;
  assign cmdIn = cbeIn_b;
  assign cfgHit = (cmdIn == hbp_pkg::CMD_CFG_RD || cmdIn == hbp_pkg::CMD_CFG_WR)
                  && (idsel || bSync[0]) && adIn[1:0] == hbp_pkg::CFG_TYPE0;
  assign memHit = (cmdIn == hbp_pkg::CMD_MEM_RD || cmdIn == hbp_pkg::CMD_MEM_WR)
                  && adIn[31:hbp_pkg::WIN_LSB] == MEM_BASE[31:hbp_pkg::WIN_LSB];
  assign tHit = stQ == hbp_pkg::S_IDLE && frameFall && (cfgHit || memHit);
  // Status codes only count while granted
  assign goMst = stQ == hbp_pkg::S_IDLE && !tHit && bReqPend_q && !gnt_b && busIdle
                 && (!bSync[0] || agpSt == hbp_pkg::ST_START);
  assign agpRdGo = stQ == hbp_pkg::S_IDLE && !tHit && !goMst && bSync[0] && !gnt_b
                   && (agpSt == hbp_pkg::ST_LP_RD || agpSt == hbp_pkg::ST_HP_RD);
  assign agpWrGo = stQ == hbp_pkg::S_IDLE && !tHit && !goMst && bSync[0] && !gnt_b && bAgpWrPend_q
                   && (agpSt == hbp_pkg::ST_LP_WR || agpSt == hbp_pkg::ST_HP_WR);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cReqTgl_q <= 1'b0;
      cAgp_q <= 1'b0;
      cWrite_q <= 1'b0;
      cCmd_q <= hbp_pkg::CMD_MEM_RD;
      cBe_q <= hbp_pkg::BE_RST;
      cAddr_q <= hbp_pkg::AD_RST;
      cData_q <= hbp_pkg::AD_RST;
      mstBusy_q <= 1'b0;
      mstDone_q <= 1'b0;
      mstAbort_q <= 1'b0;
      mstParErr_q <= 1'b0;
      mstRdData_q <= hbp_pkg::AD_RST;
      cDoneSeen_q <= 1'b0;
    end else begin
      mstDone_q <= 1'b0;
      cDoneSeen_q <= cSync[1];
      if (mstStart && !mstBusy_q) begin
        cReqTgl_q <= !cReqTgl_q;
        cAgp_q <= mstAgp;
        cWrite_q <= mstWrite;
        cCmd_q <= mstCmd;
        cBe_q <= mstBe_b;
        cAddr_q <= mstAddr;
        cData_q <= mstData;
        mstBusy_q <= 1'b1;
      end
      // Bus-side result words stay put until the next request
      if (cSync[1] != cDoneSeen_q) begin
        mstBusy_q <= 1'b0;
        mstDone_q <= 1'b1;
        mstRdData_q <= bRdData_q;
        mstAbort_q <= bAbort_q;
        mstParErr_q <= bParErr_q;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cRetSeen_q <= 1'b0;
      rdRetValid_q <= 1'b0;
      rdRetHigh_q <= 1'b0;
      rdRetData_q <= hbp_pkg::AD_RST;
    end else begin
      cRetSeen_q <= cSync[0];
      rdRetValid_q <= cSync[0] != cRetSeen_q;
      if (cSync[0] != cRetSeen_q) begin
        rdRetData_q <= bRetData_q;
        rdRetHigh_q <= bHigh_q;
      end
    end
  end

  // Request pending, bus request pin and buffer-full pin
  always_ff @(posedge busClk or negedge busRst_b) begin
    if (!busRst_b) begin
      bReqSeen_q <= 1'b0;
      bReqPend_q <= 1'b0;
      reqOut_b_q <= 1'b1;
      reqOe_q <= 1'b0;
      rbfOut_b_q <= 1'b1;
      rbfOe_q <= 1'b0;
      bFramePrev_q <= 1'b1;
    end else begin
      bReqSeen_q <= bSync[2];
      bFramePrev_q <= frameIn_b;
      if (bSync[2] != bReqSeen_q) begin
        bReqPend_q <= 1'b1;
      end else if (goMst) begin
        bReqPend_q <= 1'b0;
      end
      reqOut_b_q <= !bReqPend_q;
      reqOe_q <= 1'b1;
      // Holds off low-priority read returns while buffer is full
      rbfOut_b_q <= !bSync[1];
      rbfOe_q <= 1'b1;
    end
  end

  // Whoever drove AD last cycle drives its parity now
  always_ff @(posedge busClk or negedge busRst_b) begin
    if (!busRst_b) begin
      parOut_q <= 1'b0;
      parOe_q <= 1'b0;
    end else begin
      parOut_q <= parNext;
      parOe_q <= adOe_q;
    end
  end

  always_ff @(posedge busClk or negedge busRst_b) begin
    if (!busRst_b) begin
      for (int i = 0; i < hbp_pkg::SCR_WORDS; i++) begin
        scr_q[i] <= hbp_pkg::AD_RST;
      end
    end else if (stQ == hbp_pkg::S_TDATA && xferDone && tWr_q) begin
      for (int b = 0; b < hbp_pkg::BE_W; b++) begin
        if (!cbeIn_b[b]) begin
          scr_q[tIdx_q][8*b +: 8] <= adIn[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge busClk or negedge busRst_b) begin
    if (!busRst_b) begin
      stQ <= hbp_pkg::S_IDLE;
      adOut_q <= hbp_pkg::AD_RST;
      adOe_q <= 1'b0;
      cbeOut_b_q <= hbp_pkg::BE_RST;
      cbeOe_q <= 1'b0;
      frameOut_b_q <= 1'b1;
      frameOe_q <= 1'b0;
      irdyOut_b_q <= 1'b1;
      irdyOe_q <= 1'b0;
      trdyOut_b_q <= 1'b1;
      trdyOe_q <= 1'b0;
      stopOut_b_q <= 1'b1;
      stopOe_q <= 1'b0;
      devselOut_b_q <= 1'b1;
      devselOe_q <= 1'b0;
      pipeOut_b_q <= 1'b1;
      pipeOe_q <= 1'b0;
      tWr_q <= 1'b0;
      tIdx_q <= '0;
      abortCnt_q <= '0;
      bAgpWrPend_q <= 1'b0;
      bMstEnd_q <= 1'b0;
      bChk_q <= 1'b0;
      bAbort_q <= 1'b0;
      bParErr_q <= 1'b0;
      bDoneTgl_q <= 1'b0;
      bRetTgl_q <= 1'b0;
      bRdData_q <= hbp_pkg::AD_RST;
      bRetData_q <= hbp_pkg::AD_RST;
      bHigh_q <= 1'b0;
    end else begin
      unique case (stQ)
        hbp_pkg::S_IDLE: begin
          abortCnt_q <= '0;
          if (tHit) begin
            stQ <= hbp_pkg::S_TDATA;
            tWr_q <= cmdIn[0];
            tIdx_q <= adIn[hbp_pkg::IDX_LSB +: hbp_pkg::SCR_IDX_W];
            devselOut_b_q <= 1'b0;
            devselOe_q <= 1'b1;
            stopOut_b_q <= 1'b1;
            stopOe_q <= 1'b1;
            // Reads wait one turnaround before data and ready
            trdyOut_b_q <= !cmdIn[0];
            trdyOe_q <= 1'b1;
          end else if (goMst) begin
            adOut_q <= cAddr_q;
            adOe_q <= 1'b1;
            cbeOut_b_q <= cCmd_q;
            cbeOe_q <= 1'b1;
            bAbort_q <= 1'b0;
            bChk_q <= 1'b0;
            if (cAgp_q) begin
              stQ <= hbp_pkg::S_PIPE;
              pipeOut_b_q <= 1'b0;
              pipeOe_q <= 1'b1;
            end else begin
              stQ <= hbp_pkg::S_ADDR;
              frameOut_b_q <= 1'b0;
              frameOe_q <= 1'b1;
            end
          end else if (agpRdGo) begin
            stQ <= hbp_pkg::S_AGPR;
            bHigh_q <= agpSt[0];
            irdyOut_b_q <= 1'b0;
            irdyOe_q <= 1'b1;
          end else if (agpWrGo) begin
            stQ <= hbp_pkg::S_AGPW;
            adOut_q <= cData_q;
            adOe_q <= 1'b1;
            cbeOut_b_q <= cBe_q;
            cbeOe_q <= 1'b1;
            irdyOut_b_q <= 1'b0;
            irdyOe_q <= 1'b1;
          end
        end
        hbp_pkg::S_ADDR: begin
          stQ <= hbp_pkg::S_MDATA;
          frameOut_b_q <= 1'b1;
          irdyOut_b_q <= 1'b0;
          irdyOe_q <= 1'b1;
          cbeOut_b_q <= cBe_q;
          adOut_q <= cData_q;
          adOe_q <= cWrite_q;
        end
        hbp_pkg::S_MDATA: begin
          if (xferDone || !stopIn_b || (devselIn_b && abortCnt_q == ABORT_CNT_LAST)) begin
            stQ <= hbp_pkg::S_TURN;
            irdyOut_b_q <= 1'b1;
            frameOe_q <= 1'b0;
            adOe_q <= 1'b0;
            bMstEnd_q <= 1'b1;
            bAbort_q <= !xferDone;
            bChk_q <= xferDone && !cWrite_q;
            if (xferDone && !cWrite_q) begin
              bRdData_q <= adIn;
            end
          end else if (devselIn_b) begin
            abortCnt_q <= abortCnt_q + 1'b1;
          end
        end
        hbp_pkg::S_PIPE: begin
          // A single request, so pipe is up again after one edge
          stQ <= hbp_pkg::S_TURN;
          pipeOut_b_q <= 1'b1;
          adOe_q <= 1'b0;
          bAgpWrPend_q <= cWrite_q;
          bMstEnd_q <= !cWrite_q;
        end
        hbp_pkg::S_AGPW: begin
          if (!trdyIn_b) begin
            stQ <= hbp_pkg::S_TURN;
            irdyOut_b_q <= 1'b1;
            adOe_q <= 1'b0;
            bAgpWrPend_q <= 1'b0;
            bMstEnd_q <= 1'b1;
          end
        end
        hbp_pkg::S_AGPR: begin
          if (xferDone) begin
            stQ <= hbp_pkg::S_TURN;
            irdyOut_b_q <= 1'b1;
            bRetData_q <= adIn;
            bRetTgl_q <= !bRetTgl_q;
          end
        end
        hbp_pkg::S_TDATA: begin
          if (!tWr_q && trdyOut_b_q) begin
            adOut_q <= scr_q[tIdx_q];
            adOe_q <= 1'b1;
            trdyOut_b_q <= 1'b0;
          end else if (xferDone) begin
            trdyOut_b_q <= 1'b1;
            if (frameIn_b) begin
              stQ <= hbp_pkg::S_TURN;
              devselOut_b_q <= 1'b1;
              adOe_q <= 1'b0;
            end else begin
              // One word per access keeps the target simple; bursts disconnect
              stQ <= hbp_pkg::S_TSTOP;
              stopOut_b_q <= 1'b0;
            end
          end
        end
        hbp_pkg::S_TSTOP: begin
          if (frameIn_b) begin
            stQ <= hbp_pkg::S_TURN;
            stopOut_b_q <= 1'b1;
            devselOut_b_q <= 1'b1;
            adOe_q <= 1'b0;
          end
        end
        hbp_pkg::S_TURN: begin
          stQ <= hbp_pkg::S_IDLE;
          adOe_q <= 1'b0;
          cbeOe_q <= 1'b0;
          frameOe_q <= 1'b0;
          irdyOe_q <= 1'b0;
          trdyOe_q <= 1'b0;
          stopOe_q <= 1'b0;
          devselOe_q <= 1'b0;
          pipeOe_q <= 1'b0;
          bMstEnd_q <= 1'b0;
          if (bMstEnd_q) begin
            bDoneTgl_q <= !bDoneTgl_q;
            bParErr_q <= bChk_q && (parIn != parChk);
          end
        end
        default: stQ <= hbp_pkg::S_IDLE;
      endcase
    end
  end

  assign mstBusy = mstBusy_q;
  assign mstDone = mstDone_q;
  assign mstAbort = mstAbort_q;
  assign mstParErr = mstParErr_q;
  assign mstRdData = mstRdData_q;
  assign rdRetValid = rdRetValid_q;
  assign rdRetHigh = rdRetHigh_q;
  assign rdRetData = rdRetData_q;
  assign adOut = adOut_q;
  assign adOe = adOe_q;
  assign cbeOut_b = cbeOut_b_q;
  assign cbeOe = cbeOe_q;
  assign parOut = parOut_q;
  assign parOe = parOe_q;
  assign frameOut_b = frameOut_b_q;
  assign frameOe = frameOe_q;
  assign irdyOut_b = irdyOut_b_q;
  assign irdyOe = irdyOe_q;
  assign trdyOut_b = trdyOut_b_q;
  assign trdyOe = trdyOe_q;
  assign stopOut_b = stopOut_b_q;
  assign stopOe = stopOe_q;
  assign devselOut_b = devselOut_b_q;
  assign devselOe = devselOe_q;
  assign reqOut_b = reqOut_b_q;
  assign reqOe = reqOe_q;
  assign pipeOut_b = pipeOut_b_q;
  assign pipeOe = pipeOe_q;
  assign rbfOut_b = rbfOut_b_q;
  assign rbfOe = rbfOe_q;

  a_reset_float: assert property (@(posedge busClk) !busRst_b |-> !adOe_q && !frameOe_q && !reqOe_q)
    else $error("outputs driven during bus reset");
  a_par_owner: assert property (@(posedge busClk) disable iff (!busRst_b) parOe_q == $past(adOe_q))
    else $error("parity owner differs from data owner");
  a_par_value: assert property (@(posedge busClk) disable iff (!busRst_b)
    parOe_q |-> parOut_q == ^{$past(adOut_q), $past(cbeBus)})
    else $error("parity not even over previous cycle");
  a_addr_data: assert property (@(posedge busClk) disable iff (!busRst_b)
    stQ == hbp_pkg::S_ADDR |=> stQ == hbp_pkg::S_MDATA && !irdyOut_b_q && frameOut_b_q)
    else $error("address phase not followed by final data phase");
  a_claim_devsel: assert property (@(posedge busClk) disable iff (!busRst_b)
    tHit |=> !devselOut_b_q && devselOe_q ##1 devselOe_q)
    else $error("claimed access without device select");
  a_pipe_single: assert property (@(posedge busClk) disable iff (!busRst_b)
    $fell(pipeOut_b_q) |=> pipeOut_b_q && pipeOe_q ##1 !pipeOe_q)
    else $error("pipe held beyond one request");
  a_agpw_nowait: assert property (@(posedge busClk) disable iff (!busRst_b)
    stQ == hbp_pkg::S_AGPW && trdyIn_b |=> !irdyOut_b_q)
    else $error("wait state after AGP write ready");
  a_st_ignored: assert property (@(posedge busClk) disable iff (!busRst_b)
    stQ == hbp_pkg::S_IDLE && gnt_b |=> stQ != hbp_pkg::S_AGPR && stQ != hbp_pkg::S_AGPW)
    else $error("status used without grant");
  a_rd_valid: assert property (@(posedge busClk) disable iff (!busRst_b)
    stQ == hbp_pkg::S_TDATA && !trdyOut_b_q && !tWr_q |-> adOe_q && adOut_q == scr_q[tIdx_q])
    else $error("target ready without read data");
  a_burst_stop: assert property (@(posedge busClk) disable iff (!busRst_b)
    stQ == hbp_pkg::S_TDATA && trdyOut_b_q == 1'b0 && xferDone && !frameIn_b |=> !stopOut_b_q)
    else $error("burst not stopped");
  a_req_drive: assert property (@(posedge busClk) disable iff (!busRst_b)
    $rose(bReqPend_q) |-> ##1 !reqOut_b_q && reqOe_q)
    else $error("request pin not asserted");
  a_done_count: assert property (@(posedge clock) disable iff (!rst_b)
    mstDone_q |-> !mstBusy_q && $past(mstBusy_q))
    else $error("completion without pending request");

  c_pci_master: cover property (@(posedge busClk) disable iff (!busRst_b)
    stQ == hbp_pkg::S_MDATA && xferDone);
  c_agp_pipe: cover property (@(posedge busClk) disable iff (!busRst_b) stQ == hbp_pkg::S_PIPE);
  c_target_claim: cover property (@(posedge busClk) disable iff (!busRst_b) tHit);
  c_agp_read: cover property (@(posedge busClk) disable iff (!busRst_b)
    stQ == hbp_pkg::S_AGPR && xferDone);
endmodule // hbp_pci_agp_port
`default_nettype wire

// file: bench/hbp_chipset_model.sv
// Chipset model: arbiter, status codes, target of device-mastered cycles
`default_nettype none
module hbp_chipset_model (
  input wire logic busClk,
  input wire logic busRst_b,
  input wire logic reqOut_b,
  input wire logic rbfOut_b,
  input wire logic agpRet,
  input wire logic frameIn_b,
  input wire logic irdyIn_b,
  input wire logic [31:0] adIn,
  input wire logic [3:0] cbeIn_b,
  output logic gnt_b,
  output logic [2:0] agpSt,
  output logic pOe,
  output logic pTrdy_b,
  output logic pStop_b,
  output logic pAdOe,
  output logic [31:0] pAd,
  output logic pPar,
  output logic pParOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic retDone;
  wire logic slot = agpRet & ~retDone & rbfOut_b;
  always_ff @(posedge busClk or negedge busRst_b) begin
    if (!busRst_b) begin
      gnt_b <= 1'h1;
      agpSt <= 3'h7;
      retDone <= 1'h0;
    end else begin
      gnt_b <= reqOut_b & ~slot;
      agpSt <= slot ? 3'h0 : 3'h7;
      retDone <= agpRet & (retDone | (pOe & ~irdyIn_b & ~pTrdy_b & ~agpSt[2]));
    end
  end
  always_ff @(posedge busClk or negedge busRst_b) begin
    if (!busRst_b) begin
      pOe <= 1'h0;
      pTrdy_b <= 1'h1;
      pStop_b <= 1'h1;
      pAdOe <= 1'h0;
      pAd <= 32'h0;
    end else if (!pOe) begin
      // Stand-in for a floating bus: holds the stale word in the first cycle after release, then inverts it every cycle
      pAd <= ~pAd;
      if (!gnt_b && agpSt == 3'h0 && !irdyIn_b) begin
        pOe <= 1'h1;
        pTrdy_b <= 1'h0;
        pAdOe <= 1'h1;
        pAd <= 32'hC3A5_5A3C;
      end else if (!frameIn_b && irdyIn_b && adIn[31:28] != 4'hF) begin
        pOe <= 1'h1;
        pTrdy_b <= adIn[31:28] == 4'hE;
        pStop_b <= adIn[31:28] != 4'hE;
        pAdOe <= ~cbeIn_b[0];
        pAd <= ~adIn;
      end
    end else if (!irdyIn_b && !(pTrdy_b && pStop_b)) begin
      pOe <= 1'h0;
      pTrdy_b <= 1'h1;
      pStop_b <= 1'h1;
      pAdOe <= 1'h0;
    end
  end
  always_ff @(posedge busClk or negedge busRst_b) begin
    if (!busRst_b) begin
      pPar <= 1'h0;
      pParOe <= 1'h0;
    end else begin
      pPar <= ^{adIn, cbeIn_b};
      pParOe <= pAdOe;
    end
  end
endmodule // hbp_chipset_model
`default_nettype wire

// file: bench/tb_hbp_pci_agp_port.sv
// Bench for the host bus port facing the chipset model
`default_nettype none
module tb_hbp_pci_agp_port;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic md; logic wr; logic [3:0] cmd; logic [31:0] ad; logic [31:0] dt; logic ab;} hbp_row_t;
  hbp_row_t rows [6] = '{'{1'h1, 1'h1, 4'h7, 32'h1000, 32'h1234_5678, 1'h0},
    '{1'h0, 1'h0, 4'h6, 32'h2000, 32'hFFFF_DFFF, 1'h0}, '{1'h1, 1'h0, 4'hA, 32'h100, 32'hFFFF_FEFF, 1'h0},
    '{1'h0, 1'h1, 4'hB, 32'h200, 32'h0BAD_F00D, 1'h0}, '{1'h0, 1'h1, 4'h7, 32'hF000_0000, 32'h0, 1'h1},
    '{1'h1, 1'h0, 4'h6, 32'hE000_0000, 32'h0, 1'h1}};
  logic clock = 1'h0, busClk = 1'h0, rst_b = 1'h0, busRst_b = 1'h0, mstStart = 1'h0, mstWrite = 1'h0;
  logic agpMode = 1'h0, readBufFull = 1'h0, agpRet = 1'h0, mstAgp = 1'h0;
  // Outside master on the bus, for the target tests
  logic tFrame_b = 1'h1, tIrdy_b = 1'h1, tAdOe = 1'h0;
  logic [3:0] tCbe = 4'h0;
  logic [31:0] tAd = 32'h0;
  logic [3:0] mstCmd = 4'h0, mstBe_b = 4'h5, cbeOut_b;
  logic [31:0] mstAddr = 32'h0, mstData = 32'h0, mstRdData, rdRetData, adOut, pAd;
  logic mstBusy, mstDone, mstAbort, mstParErr, rdRetValid, rdRetHigh, adOe, cbeOe, parOut, parOe, pp;
  logic frameOut_b, frameOe, irdyOut_b, irdyOe, trdyOut_b, trdyOe, stopOut_b, stopOe, devselOut_b, devselOe;
  logic reqOut_b, reqOe, pipeOut_b, pipeOe, rbfOut_b, rbfOe, gnt_b, pOe, pTrdy_b, pStop_b, pAdOe, pPar, pParOe;
  logic [2:0] agpSt;
  wire logic tOe = !tFrame_b || !tIrdy_b;
  wire logic [31:0] adIn = adOe ? adOut : (tAdOe ? tAd : pAd);
  wire logic [3:0] cbeIn_b = cbeOe ? cbeOut_b : (tOe ? tCbe : pAd[7:4]);
  wire logic parIn = parOe ? parOut : (pParOe ? pPar : pAd[8]);
  wire logic frameIn_b = frameOe ? frameOut_b : tFrame_b;
  wire logic irdyIn_b = irdyOe ? irdyOut_b : tIrdy_b;
  wire logic [10:0] oes = {adOe, cbeOe, parOe, frameOe, irdyOe, trdyOe, stopOe, devselOe, reqOe, pipeOe, rbfOe};
  wire logic trdyIn_b = trdyOe ? trdyOut_b : (pOe ? pTrdy_b : 1'h1);
  wire logic stopIn_b = stopOe ? stopOut_b : (pOe ? pStop_b : 1'h1);
  wire logic devselIn_b = devselOe ? devselOut_b : ~pOe;
  int checks = 0, n_mismatch = 0;
  hbp_pci_agp_port #(.ABORT_CYC(5)) dut (.clock, .rst_b, .mstStart, .mstAgp, .mstWrite, .mstCmd, .mstAddr,
    .mstData, .mstBe_b, .readBufFull, .agpMode, .mstBusy, .mstDone, .mstAbort, .mstParErr, .mstRdData, .rdRetValid,
    .rdRetHigh, .rdRetData, .busClk, .busRst_b, .adIn, .adOut, .adOe, .cbeIn_b, .cbeOut_b, .cbeOe, .parIn, .parOut,
    .parOe, .frameIn_b, .frameOut_b, .frameOe, .irdyIn_b, .irdyOut_b, .irdyOe, .trdyIn_b, .trdyOut_b, .trdyOe,
    .stopIn_b, .stopOut_b, .stopOe, .devselIn_b, .devselOut_b, .devselOe, .idsel(1'h0), .gnt_b, .agpSt, .reqOut_b,
    .reqOe, .pipeOut_b, .pipeOe, .rbfOut_b, .rbfOe);
  hbp_chipset_model chipset (.busClk, .busRst_b, .reqOut_b, .rbfOut_b, .agpRet, .frameIn_b, .irdyIn_b, .adIn,
    .cbeIn_b, .gnt_b, .agpSt, .pOe, .pTrdy_b, .pStop_b, .pAdOe, .pAd, .pPar, .pParOe);
  always #5 clock = ~clock;
  always #62.5 busClk = ~busClk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("Counts: checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait on the core pulse; a miss is caught by the check after it
  task automatic waitFor(input bit ret);
    int n;
    n = 0;
    while ((ret ? rdRetValid : mstDone) !== 1'h1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    chk("completion", 1'h1, ret ? rdRetValid : mstDone);
  endtask
  // One config access as outside master; idle gap first so the frame edge is seen
  task automatic tgt(input logic [3:0] cmd, input logic [3:0] be, input logic [31:0] dt, input bit burst);
    int n;
    n = 0;
    repeat (2) @(posedge busClk);
    tFrame_b <= 1'h0;
    tAdOe <= 1'h1;
    tAd <= 32'hF000_0004;
    tCbe <= cmd;
    @(posedge busClk);
    tFrame_b <= !burst;
    tIrdy_b <= 1'h0;
    tAdOe <= cmd[0];
    tAd <= dt;
    tCbe <= be;
    do begin
      @(posedge busClk);
      n++;
    end while (trdyIn_b !== 1'h0 && n < 8);
    chk("target ready", 1'h0, trdyIn_b);
    chk("target select", 1'h0, devselIn_b);
    if (!cmd[0]) chk("target read", dt, adIn);
    if (burst) @(posedge busClk);
    if (burst) chk("target stop", 1'h0, stopIn_b);
    tFrame_b <= 1'h1;
    tIrdy_b <= 1'h1;
    tAdOe <= 1'h0;
  endtask
  // Wire monitor: parity trails the word it covers by one bus cycle
  always @(posedge busClk) begin
    pp <= ^{adIn, cbeIn_b};
    if (parOe === 1'h1) chk("parity", pp, parOut);
    if (frameOe === 1'h1 && !frameOut_b && irdyIn_b) chk("address", mstAddr, adIn);
    if (frameOe === 1'h1 && !frameOut_b && irdyIn_b) chk("command", mstCmd, cbeIn_b);
    if (adOe === 1'h1 && irdyOe === 1'h1 && !irdyIn_b && !trdyIn_b) chk("write data", mstData, adIn);
    if (adOe === 1'h1 && irdyOe === 1'h1 && !irdyIn_b && !trdyIn_b) chk("byte enables", mstBe_b, cbeIn_b);
    if (pipeOe === 1'h1 && !pipeOut_b) chk("pipe address", mstAddr, adIn);
    if (pipeOe === 1'h1 && !pipeOut_b) chk("pipe command", mstCmd, cbeIn_b);
  end
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'h1;
    chk("enables in reset", 11'h0, oes);
    chk("core in reset", 3'h0, {mstBusy, mstDone, rdRetValid});
    @(posedge busClk) busRst_b <= 1'h1;
    repeat (4) @(posedge busClk);
    chk("request idle", 1'h1, reqOut_b);
    $display("Test reset done");
    foreach (rows[i]) begin
      @(posedge clock);
      agpMode <= rows[i].md;
      mstWrite <= rows[i].wr;
      mstCmd <= rows[i].cmd;
      mstAddr <= rows[i].ad;
      mstData <= rows[i].dt;
      mstStart <= 1'h1;
      @(posedge clock);
      mstStart <= 1'h0;
      waitFor(1'b0);
      chk("abort", rows[i].ab, mstAbort);
      if (!rows[i].wr && !rows[i].ab) chk("read data", rows[i].dt, mstRdData);
      if (!rows[i].wr && !rows[i].ab) chk("read parity", 1'h0, mstParErr);
      $display("Test row %0d done", i);
    end
    @(posedge clock);
    mstAgp <= 1'h1;
    mstWrite <= 1'h0;
    mstAddr <= 32'h0000_3000;
    mstStart <= 1'h1;
    @(posedge clock);
    mstStart <= 1'h0;
    waitFor(1'b0);
    chk("pipe abort", 1'h0, mstAbort);
    mstAgp <= 1'h0;
    $display("Test pipe request done");
    tgt(4'hB, 4'hA, 32'h1234_5678, 1'b1);
    tgt(4'hA, 4'h0, 32'h0034_0078, 1'b0);
    $display("Test target done");
    agpRet <= 1'h1;
    waitFor(1'b1);
    chk("return data", 32'hC3A5_5A3C, rdRetData);
    chk("return priority", 1'h0, rdRetHigh);
    agpRet <= 1'h0;
    $display("Test read return done");
    readBufFull <= 1'h1;
    repeat (60) @(posedge clock);
    chk("buffer full pin", 1'h0, rbfOut_b);
    $display("Test buffer full done");
    conclude();
  end
endmodule // tb_hbp_pci_agp_port
`default_nettype wire
